// ---- ddrcm_consts.svh ----
// Constants for the DDR command and mode-register controller
`ifndef DDRCM_CONSTS_SVH
`define DDRCM_CONSTS_SVH

// Address field positions
`define DDRCM_BL_HI         2
`define DDRCM_BL_LO         0
`define DDRCM_SET_HI        6
`define DDRCM_OPM_LO        7
`define DDRCM_LOOP_RST_BIT  8
`define DDRCM_OPM_UP_LO     9
`define DDRCM_PRE_SEL_BIT   10
`define DDRCM_EXT_DLL_DIS   0

// Burst length codes
`define DDRCM_BL_CODE_2     3'h1
`define DDRCM_BL_CODE_4     3'h2
`define DDRCM_BL_CODE_8     3'h3

// Timing counts in memory clock slots
`define DDRCM_DLL_LOCK_CK   8'hc8
`define DDRCM_MRD_CK        2'h2

// Reset values
`define DDRCM_MR_RST        13'h0000
`define DDRCM_EMR_RST       13'h0000
`define DDRCM_MASK_RST      8'h00

`endif

// ---- ddrcm_pkg.sv ----
// Types for the DDR command and mode-register controller
package ddrcm_pkg;

  typedef enum logic [3:0] {
    CMD_NOP   = 4'h0,
    CMD_ACT   = 4'h1,
    CMD_RD    = 4'h2,
    CMD_WR    = 4'h3,
    CMD_BST   = 4'h4,
    CMD_PRE   = 4'h5,
    CMD_REF   = 4'h6,
    CMD_SREF  = 4'h7,
    CMD_LMR   = 4'h8,
    CMD_SREX  = 4'h9,
    CMD_DESEL = 4'ha
  } ddrcm_cmd_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_LOOPRS = 2'b10,
    ST_NORMAL = 2'b11
  } ddrcm_state_t;

endpackage

// ---- ddrcm_pin_if.sv ----
// Command to pin-strobe bundle between controller and encoder
`timescale 1ns/1ps
interface ddrcm_pin_if #(
  parameter int AW = 13
);
  ddrcm_pkg::ddrcm_cmd_t cmd;
  logic [1:0]            ba_in;
  logic [AW-1:0]         addr_in;
  logic                  cs_n;
  logic                  ras_n;
  logic                  cas_n;
  logic                  we_n;
  logic [1:0]            ba_out;
  logic [AW-1:0]         addr_out;

  modport ctrl (output cmd, output ba_in, output addr_in,
                input cs_n, input ras_n, input cas_n, input we_n, input ba_out, input addr_out);
  modport enc  (input cmd, input ba_in, input addr_in,
                output cs_n, output ras_n, output cas_n, output we_n, output ba_out, output addr_out);
endinterface

// ---- ddrcm_cmd_enc.sv ----
// Command encoder: command code to chip-select and strobe levels
`timescale 1ns/1ps
module ddrcm_cmd_enc (
  ddrcm_pin_if.enc pif
);

  // Strobe levels {cs_n, ras_n, cas_n, we_n}
  function automatic logic [3:0] enc_strobes(input ddrcm_pkg::ddrcm_cmd_t c);
    case (c)
      ddrcm_pkg::CMD_DESEL: enc_strobes = 4'hf;
      ddrcm_pkg::CMD_ACT:   enc_strobes = 4'h3;
      ddrcm_pkg::CMD_RD:    enc_strobes = 4'h5;
      ddrcm_pkg::CMD_WR:    enc_strobes = 4'h4;
      ddrcm_pkg::CMD_BST:   enc_strobes = 4'h6;
      ddrcm_pkg::CMD_PRE:   enc_strobes = 4'h2;
      ddrcm_pkg::CMD_REF:   enc_strobes = 4'h1;
      ddrcm_pkg::CMD_SREF:  enc_strobes = 4'h1;
      ddrcm_pkg::CMD_LMR:   enc_strobes = 4'h0;
      default:              enc_strobes = 4'h7;
    endcase
  endfunction

  wire [3:0] strobes_w;
  wire       addr_used_w;

  assign strobes_w = enc_strobes(pif.cmd);
  // Address only carried where the command consumes it
  assign addr_used_w = (pif.cmd == ddrcm_pkg::CMD_ACT) || (pif.cmd == ddrcm_pkg::CMD_RD) ||
                       (pif.cmd == ddrcm_pkg::CMD_WR) || (pif.cmd == ddrcm_pkg::CMD_PRE) ||
                       (pif.cmd == ddrcm_pkg::CMD_LMR);

  assign pif.cs_n     = strobes_w[3];
  assign pif.ras_n    = strobes_w[2];
  assign pif.cas_n    = strobes_w[1];
  assign pif.we_n     = strobes_w[0];
  assign pif.ba_out   = addr_used_w ? pif.ba_in : 2'h0;
  assign pif.addr_out = addr_used_w ? pif.addr_in : '0;

endmodule

// ---- ddrcm_ctrl.sv ----
// DDR command and mode-register controller driving the memory pins
`timescale 1ns/1ps
`include "ddrcm_consts.svh"

module ddrcm_ctrl #(
  parameter int AW      = 13,
  parameter int CK_HALF = 1
) (
  // Clock and reset
  input  wire logic                  mclk_i,
  input  wire logic                  rstn_i,
  // User request
  input  wire logic                  req_valid_i,
  input  wire ddrcm_pkg::ddrcm_cmd_t req_cmd_i,
  input  wire logic [1:0]            req_bank_i,
  input  wire logic [AW-1:0]         req_addr_i,
  input  wire logic [7:0]            req_mask_i,
  // User status
  output logic                       req_ready_o,
  output logic                       req_done_o,
  output logic                       req_err_o,
  output logic                       dll_ready_o,
  // Memory pins
  output logic                       mem_ck_o,
  output logic                       mem_ck_n_o,
  output logic                       mem_cke_o,
  output logic                       mem_cs_n_o,
  output logic                       mem_ras_n_o,
  output logic                       mem_cas_n_o,
  output logic                       mem_we_n_o,
  output logic [1:0]                 bank_bit_o,
  output logic [AW-1:0]              mem_addr_o,
  output logic                       write_mask_o
);

  localparam int HW = (CK_HALF > 1) ? $clog2(CK_HALF) : 1;
  // Upper operating-mode bits legal: all zero, or only the loop reset bit
  function automatic logic op_mode_ok(input logic [AW-1:0] a);
    op_mode_ok = (a[AW-1:`DDRCM_OPM_UP_LO] == '0) && !a[`DDRCM_OPM_LO];
  endfunction

  // Burst length in clock slots from the base register code
  function automatic logic [2:0] burst_slots(input logic [2:0] code);
    case (code)
      `DDRCM_BL_CODE_2: burst_slots = 3'h1;
      `DDRCM_BL_CODE_4: burst_slots = 3'h2;
      `DDRCM_BL_CODE_8: burst_slots = 3'h4;
      default:          burst_slots = 3'h1;
    endcase
  endfunction

  ddrcm_pkg::ddrcm_state_t state_q, state_d;
  logic [HW-1:0]  half_cnt_q;
  logic           ck_q, ck_n_q;
  logic           cke_q;
  logic           cs_n_q, ras_n_q, cas_n_q, we_n_q;
  logic [1:0]     ba_q;
  logic [AW-1:0]  addr_q;
  logic           ready_q, done_q, err_q, dll_rdy_q;
  ddrcm_pkg::ddrcm_cmd_t hcmd_q;
  logic [1:0]     hba_q;
  logic [AW-1:0]  haddr_q;
  logic [7:0]     hmask_q;
  logic [AW-1:0]  mr_q;
  logic [AW-1:0]  emr_q;
  logic [3:0]     open_q;
  logic [2:0]     burst_q;
  logic           rd_noap_q;
  logic [7:0]     dll_cnt_q;
  logic [1:0]     gap_q;
  logic [7:0]     wm_sr_q;
  logic [3:0]     wm_beats_q;
  logic [1:0]     wm_dly_q;
  logic           wmask_q;

  ddrcm_pin_if #(.AW(AW)) pin_if ();
  ddrcm_cmd_enc u_enc (
    .pif (pin_if.enc)
  );

  // Clock divider and slot ticks
  wire half_tick = (half_cnt_q == HW'(CK_HALF - 1));
  wire slot_tick = half_tick && ck_q;

  // Held request decode
  wire is_lmr     = (hcmd_q == ddrcm_pkg::CMD_LMR);
  wire lmr_base   = is_lmr && (hba_q == 2'h0);
  wire lmr_ext    = is_lmr && (hba_q == 2'h1);
  wire pre_sel    = haddr_q[`DDRCM_PRE_SEL_BIT];
  wire bank_open  = open_q[hba_q];
  wire all_idle   = (open_q == 4'h0) && (burst_q == 3'h0);
  wire gap_zero   = (gap_q == 2'h0);

  // Legality of the held command against device state
  wire lmr_ok  = all_idle && (lmr_ext || (lmr_base && op_mode_ok(haddr_q)));
  wire cmd_ok =
    (hcmd_q == ddrcm_pkg::CMD_SREX)  ? !cke_q :
    !cke_q                           ? 1'b0 :
    (hcmd_q == ddrcm_pkg::CMD_NOP)   ? 1'b1 :
    (hcmd_q == ddrcm_pkg::CMD_DESEL) ? 1'b1 :
    (hcmd_q == ddrcm_pkg::CMD_ACT)   ? !bank_open :
    (hcmd_q == ddrcm_pkg::CMD_RD)    ? bank_open && (dll_cnt_q == 8'h00) && !emr_q[`DDRCM_EXT_DLL_DIS] :
    (hcmd_q == ddrcm_pkg::CMD_WR)    ? bank_open :
    (hcmd_q == ddrcm_pkg::CMD_BST)   ? (burst_q != 3'h0) && rd_noap_q :
    (hcmd_q == ddrcm_pkg::CMD_PRE)   ? 1'b1 :
    (hcmd_q == ddrcm_pkg::CMD_REF)   ? all_idle :
    (hcmd_q == ddrcm_pkg::CMD_SREF)  ? all_idle :
    is_lmr                           ? lmr_ok : 1'b0;

  wire wait_go   = (state_q == ddrcm_pkg::ST_WAIT) && slot_tick && gap_zero;
  wire user_iss  = wait_go && cmd_ok;
  wire auto_iss  = slot_tick && gap_zero &&
                   ((state_q == ddrcm_pkg::ST_LOOPRS) || (state_q == ddrcm_pkg::ST_NORMAL));
  // Automatic mode writes keep the chosen low settings
  wire [AW-1:0] auto_addr = (state_q == ddrcm_pkg::ST_LOOPRS) ?
                            (AW'(mr_q[`DDRCM_SET_HI:0]) | (AW'(1) << `DDRCM_LOOP_RST_BIT)) :
                            AW'(mr_q[`DDRCM_SET_HI:0]);

  // Command presented to the encoder
  wire ddrcm_pkg::ddrcm_cmd_t sel_cmd =
    auto_iss ? ddrcm_pkg::CMD_LMR :
    (user_iss && hcmd_q != ddrcm_pkg::CMD_SREX) ? hcmd_q : ddrcm_pkg::CMD_NOP;
  assign pin_if.cmd     = sel_cmd;
  assign pin_if.ba_in   = auto_iss ? 2'h0 : hba_q;
  assign pin_if.addr_in = auto_iss ? auto_addr : haddr_q;

  // Register updates on issue
  wire iss_lmr_base = (user_iss && lmr_base) || auto_iss;
  wire [AW-1:0] lmr_val = auto_iss ? auto_addr : haddr_q;
  wire ext_dll_on   = user_iss && lmr_ext && !haddr_q[`DDRCM_EXT_DLL_DIS];
  wire iss_rdwr     = user_iss && ((hcmd_q == ddrcm_pkg::CMD_RD) || (hcmd_q == ddrcm_pkg::CMD_WR));
  wire iss_wr       = user_iss && (hcmd_q == ddrcm_pkg::CMD_WR);
  wire [2:0] bl_sl  = burst_slots(mr_q[`DDRCM_BL_HI:`DDRCM_BL_LO]);
  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ddrcm_pkg::ST_IDLE:   if (req_valid_i && ready_q) state_d = ddrcm_pkg::ST_WAIT;
      ddrcm_pkg::ST_WAIT: begin
        if (wait_go) begin
          if (user_iss && lmr_base && haddr_q[`DDRCM_LOOP_RST_BIT]) begin
            state_d = ddrcm_pkg::ST_NORMAL;
          end else if (ext_dll_on) begin
            state_d = ddrcm_pkg::ST_LOOPRS;
          end else begin
            state_d = ddrcm_pkg::ST_IDLE;
          end
        end
      end
      ddrcm_pkg::ST_LOOPRS: if (auto_iss) state_d = ddrcm_pkg::ST_NORMAL;
      ddrcm_pkg::ST_NORMAL: if (auto_iss) state_d = ddrcm_pkg::ST_IDLE;
      default: state_d = ddrcm_pkg::ST_IDLE;
    endcase
  end

  // Memory clock divider
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      half_cnt_q <= '0;
      ck_q       <= 1'b0;
      ck_n_q     <= 1'b1;
    end else begin
      half_cnt_q <= half_tick ? '0 : half_cnt_q + HW'(1);
      ck_q       <= half_tick ? !ck_q : ck_q;
      ck_n_q     <= half_tick ? ck_q : ck_n_q;
    end
  end

  // State and user handshake
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q   <= ddrcm_pkg::ST_IDLE;
      ready_q   <= 1'b0;
      done_q    <= 1'b0;
      err_q     <= 1'b0;
      dll_rdy_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      ready_q   <= (state_d == ddrcm_pkg::ST_IDLE);
      done_q    <= user_iss;
      err_q     <= wait_go && !cmd_ok;
      dll_rdy_q <= (dll_cnt_q == 8'h00) && !ext_dll_on && !(user_iss && hcmd_q == ddrcm_pkg::CMD_SREX);
    end
  end

  // Held request
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hcmd_q  <= ddrcm_pkg::CMD_NOP;
      hba_q   <= 2'h0;
      haddr_q <= '0;
      hmask_q <= `DDRCM_MASK_RST;
    end else if (req_valid_i && ready_q) begin
      hcmd_q  <= req_cmd_i;
      hba_q   <= req_bank_i;
      haddr_q <= req_addr_i;
      hmask_q <= req_mask_i;
    end
  end

  // Pins change on the falling memory clock edge, stable at the rising one
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= 4'hf;
      {ba_q, addr_q}                     <= '0;
    end else if (slot_tick) begin
      {cs_n_q, ras_n_q, cas_n_q, we_n_q} <= {pin_if.cs_n, pin_if.ras_n, pin_if.cas_n, pin_if.we_n};
      {ba_q, addr_q}                     <= {pin_if.ba_out, pin_if.addr_out};
    end
  end

  // Clock enable and loop lock count
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cke_q     <= 1'b1;
      dll_cnt_q <= `DDRCM_DLL_LOCK_CK;
    end else begin
      if (user_iss && hcmd_q == ddrcm_pkg::CMD_SREF) begin
        cke_q <= 1'b0;
      end else if (user_iss && hcmd_q == ddrcm_pkg::CMD_SREX) begin
        cke_q <= 1'b1;
      end
      if (ext_dll_on || (user_iss && hcmd_q == ddrcm_pkg::CMD_SREX)) begin
        dll_cnt_q <= `DDRCM_DLL_LOCK_CK;
      end else if (slot_tick && cke_q && dll_cnt_q != 8'h00) begin
        dll_cnt_q <= dll_cnt_q - 8'h01;
      end
    end
  end

  // Mode register shadows and post-write gap
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mr_q  <= AW'(`DDRCM_MR_RST);
      emr_q <= AW'(`DDRCM_EMR_RST);
      gap_q <= 2'h0;
    end else begin
      if (iss_lmr_base) begin
        mr_q <= lmr_val & ~(AW'(1) << `DDRCM_LOOP_RST_BIT);
      end
      if (user_iss && lmr_ext) begin
        emr_q <= haddr_q;
      end
      if (iss_lmr_base || (user_iss && lmr_ext)) begin
        gap_q <= `DDRCM_MRD_CK;
      end else if (slot_tick && !gap_zero) begin
        gap_q <= gap_q - 2'h1;
      end
    end
  end

  // Bank and burst tracking
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      open_q    <= 4'h0;
      burst_q   <= 3'h0;
      rd_noap_q <= 1'b0;
    end else begin
      if (user_iss && hcmd_q == ddrcm_pkg::CMD_ACT) begin
        open_q[hba_q] <= 1'b1;
      end else if (user_iss && hcmd_q == ddrcm_pkg::CMD_PRE) begin
        open_q <= pre_sel ? 4'h0 : (open_q & ~(4'h1 << hba_q));
      end else if (iss_rdwr && pre_sel) begin
        open_q[hba_q] <= 1'b0;
      end
      if (iss_rdwr) begin
        burst_q   <= bl_sl;
        rd_noap_q <= (hcmd_q == ddrcm_pkg::CMD_RD) && !pre_sel;
      end else if (user_iss && hcmd_q == ddrcm_pkg::CMD_BST) begin
        burst_q <= 3'h0;
      end else if (slot_tick && burst_q != 3'h0) begin
        burst_q <= burst_q - 3'h1;
      end
    end
  end

  // Write mask beats, one per memory clock edge
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wm_sr_q    <= `DDRCM_MASK_RST;
      wm_beats_q <= 4'h0;
      wm_dly_q   <= 2'h0;
      wmask_q    <= 1'b0;
    end else if (iss_wr) begin
      wm_sr_q    <= hmask_q;
      wm_beats_q <= {bl_sl, 1'b0};
      wm_dly_q   <= 2'h2;
    end else if (half_tick) begin
      if (wm_dly_q != 2'h0) begin
        wm_dly_q <= wm_dly_q - 2'h1;
      end else if (wm_beats_q != 4'h0) begin
        wmask_q    <= wm_sr_q[0];
        wm_sr_q    <= {1'b0, wm_sr_q[7:1]};
        wm_beats_q <= wm_beats_q - 4'h1;
      end else begin
        wmask_q <= 1'b0;
      end
    end
  end

  assign req_ready_o  = ready_q;
  assign req_done_o   = done_q;
  assign req_err_o    = err_q;
  assign dll_ready_o  = dll_rdy_q;
  assign mem_ck_o     = ck_q;
  assign mem_ck_n_o   = ck_n_q;
  assign mem_cke_o    = cke_q;
  assign mem_cs_n_o   = cs_n_q;
  assign mem_ras_n_o  = ras_n_q;
  assign mem_cas_n_o  = cas_n_q;
  assign mem_we_n_o   = we_n_q;
  assign bank_bit_o   = ba_q;
  assign mem_addr_o   = addr_q;
  assign write_mask_o = wmask_q;

endmodule

// ---- ddrcm_ctrl_checker.sv ----
// Assertions on the controller's memory pins and status
`timescale 1ns/1ps
module ddrcm_ctrl_checker #(
  parameter int AW      = 13,
  parameter int CK_HALF = 1
) (
  // Clock and reset
  input wire logic          mclk_i,
  input wire logic          rstn_i,
  // Status
  input wire logic          req_done_o,
  input wire logic          req_err_o,
  input wire logic          dll_ready_o,
  // Memory pins
  input wire logic          mem_ck_o,
  input wire logic          mem_cke_o,
  input wire logic          mem_cs_n_o,
  input wire logic          mem_ras_n_o,
  input wire logic          mem_cas_n_o,
  input wire logic          mem_we_n_o,
  input wire logic [1:0]    bank_bit_o,
  input wire logic [AW-1:0] mem_addr_o
);
  wire [3:0] pins     = {mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o};
  wire       lmr_w    = pins == 4'h0;
  wire       base_w   = lmr_w && bank_bit_o == 2'h0;
  wire       rst_w    = base_w && mem_addr_o[8];
  wire       ext_en_w = lmr_w && bank_bit_o == 2'h1 && !mem_addr_o[0];

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  property p_launch; !$stable({mem_ras_n_o, mem_cas_n_o, mem_we_n_o}) |-> $fell(mem_ck_o); endproperty
  a_launch: assert property (p_launch) else $error("Command changed off a falling memory clock");
  property p_read_dll; pins == 4'h5 |-> dll_ready_o; endproperty
  a_read_dll: assert property (p_read_dll) else $error("Read issued before loop settled");
  property p_lmr_bank; lmr_w |-> !bank_bit_o[1]; endproperty
  a_lmr_bank: assert property (p_lmr_bank) else $error("Mode write to reserved bank code");
  property p_opmode; base_w |-> mem_addr_o[AW-1:9] == '0 && !mem_addr_o[7]; endproperty
  a_opmode: assert property (p_opmode) else $error("Reserved operating mode written");
  property p_follow_rst; $rose(rst_w) |-> ##[2:40] (base_w && !mem_addr_o[8]); endproperty
  a_follow_rst: assert property (p_follow_rst) else $error("No normal write after loop reset");
  property p_follow_en; $rose(ext_en_w) |-> ##[2:40] rst_w; endproperty
  a_follow_en: assert property (p_follow_en) else $error("No loop reset after loop enable");
  property p_ref_addr; pins == 4'h1 |-> mem_addr_o == '0; endproperty
  a_ref_addr: assert property (p_ref_addr) else $error("Refresh with address driven");
  property p_sref_cke; $fell(mem_cke_o) |-> (pins == 4'h1 || $past(pins) == 4'h1); endproperty
  a_sref_cke: assert property (p_sref_cke) else $error("Clock enable dropped without refresh");
  property p_one_answer; req_err_o |-> !req_done_o ##1 !req_err_o; endproperty
  a_one_answer: assert property (p_one_answer) else $error("Refusal not a lone pulse");
endmodule

bind ddrcm_ctrl ddrcm_ctrl_checker #(.AW(AW), .CK_HALF(CK_HALF)) ddrcm_ctrl_checker_inst (
  .mclk_i, .rstn_i, .req_done_o, .req_err_o, .dll_ready_o, .mem_ck_o, .mem_cke_o,
  .mem_cs_n_o, .mem_ras_n_o, .mem_cas_n_o, .mem_we_n_o, .bank_bit_o, .mem_addr_o);

// ---- ddrcm_mem_model.sv ----
// Behavioural memory device decoding the controller's pins
`timescale 1ns/1ps
module ddrcm_mem_model (
  // Clock
  input wire logic        ck_i,
  input wire logic        cke_i,
  // Command
  input wire logic        cs_n_i,
  input wire logic        ras_n_i,
  input wire logic        cas_n_i,
  input wire logic        we_n_i,
  input wire logic [1:0]  bank_i,
  input wire logic [12:0] addr_i,
  // Mask
  input wire logic        write_mask_i
);
  logic [12:0] mr_q     = 13'h0000;
  logic [12:0] emr_q    = 13'h0000;
  logic [3:0]  open_q   = 4'h0;
  logic        sref_q   = 1'b0;
  logic        dll_on_q = 1'b0;
  int          n_ref    = 0;
  int          n_lrst   = 0;
  int          n_mask   = 0;
  wire [3:0]   pins     = {cs_n_i, ras_n_i, cas_n_i, we_n_i};

  always @(posedge ck_i) begin
    if (sref_q) begin
      if (cke_i) begin
        sref_q = 1'b0;
        dll_on_q = 1'b1;
      end
    end else if (!cke_i) begin
      if (pins == 4'h1) begin
        sref_q = 1'b1;
        dll_on_q = 1'b0;
      end
    end else if (!pins[3]) begin
      case (pins[2:0])
        3'b011: open_q[bank_i] = 1'b1;
        3'b101, 3'b100: if (addr_i[10]) open_q[bank_i] = 1'b0;
        3'b010: if (addr_i[10]) open_q = 4'h0; else open_q[bank_i] = 1'b0;
        3'b001: n_ref++;
        3'b000: if (bank_i == 2'h1) begin
            emr_q = addr_i;
            dll_on_q = !addr_i[0];
          end else if (bank_i == 2'h0) begin
            mr_q = addr_i & 13'h1eff;
            if (addr_i[8]) n_lrst++;
          end
        default: ;
      endcase
    end
  end

  always @(ck_i) begin
    #1;
    if (write_mask_i) n_mask++;
  end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the DDR command and mode-register controller
`timescale 1ns/1ps
module tb_top;
  // Design inputs
  logic                  mclk_i      = 1'b0;
  logic                  rstn_i      = 1'b0;
  logic                  req_valid_i = 1'b0;
  ddrcm_pkg::ddrcm_cmd_t req_cmd_i   = ddrcm_pkg::CMD_NOP;
  logic [1:0]            req_bank_i  = 2'h0;
  logic [12:0]           req_addr_i  = 13'h0000;
  logic [7:0]            req_mask_i  = 8'h00;
  // Design outputs
  logic        req_ready_o, req_done_o, req_err_o, dll_ready_o, mem_ck_o, mem_cke_o;
  logic        mem_cs_n_o, mem_ras_n_o, mem_cas_n_o, mem_we_n_o, write_mask_o, mem_ck_n_o;
  logic [1:0]  bank_bit_o;
  logic [12:0] mem_addr_o;
  int          n_fail      = 0;
  int          check_count = 0;

  always #2.5 mclk_i = ~mclk_i;

  ddrcm_ctrl ddrcm_ctrl_inst (.mclk_i, .rstn_i, .req_valid_i, .req_cmd_i, .req_bank_i, .req_addr_i,
    .req_mask_i, .req_ready_o, .req_done_o, .req_err_o, .dll_ready_o, .mem_ck_o, .mem_ck_n_o,
    .mem_cke_o, .mem_cs_n_o, .mem_ras_n_o, .mem_cas_n_o, .mem_we_n_o, .bank_bit_o, .mem_addr_o,
    .write_mask_o);
  ddrcm_mem_model ddrcm_mem_model_inst (.ck_i(mem_ck_o), .cke_i(mem_cke_o), .cs_n_i(mem_cs_n_o),
    .ras_n_i(mem_ras_n_o), .cas_n_i(mem_cas_n_o), .we_n_i(mem_we_n_o), .bank_i(bank_bit_o),
    .addr_i(mem_addr_o), .write_mask_i(write_mask_o));

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic hang();
    n_fail++;
    $display("[FAIL] t=%0t got=%h exp=%h wait ran out", $time, 0, 1);
    summarize();
  endtask

  task automatic wait_ready();
    int k;
    k = 0;
    @(negedge mclk_i);
    while (req_ready_o !== 1'b1) begin
      if (++k > 2000) hang();
      @(negedge mclk_i);
    end
  endtask

  task automatic settle();
    wait_ready();
    repeat (6) @(negedge mclk_i);
  endtask

  task automatic issue(input ddrcm_pkg::ddrcm_cmd_t c, input logic [1:0] b, input logic [12:0] a,
                       input logic [7:0] m, input logic e);
    int k;
    k = 0;
    wait_ready();
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    req_cmd_i <= c;
    req_bank_i <= b;
    req_addr_i <= a;
    req_mask_i <= m;
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    @(negedge mclk_i);
    while (req_done_o !== 1'b1 && req_err_o !== 1'b1) begin
      if (++k > 100) hang();
      @(negedge mclk_i);
    end
    chk(req_err_o, e);
  endtask

  task automatic t_mode();
    issue(ddrcm_pkg::CMD_LMR, 2'h0, 13'h0033, 8'h00, 1'b0);
    settle();
    chk(ddrcm_mem_model_inst.mr_q, 13'h0033);
    issue(ddrcm_pkg::CMD_LMR, 2'h0, 13'h0133, 8'h00, 1'b0);
    settle();
    chk(ddrcm_mem_model_inst.n_lrst, 1);
    chk(ddrcm_mem_model_inst.mr_q, 13'h0033);
    issue(ddrcm_pkg::CMD_LMR, 2'h1, 13'h0002, 8'h00, 1'b0);
    settle();
    chk(ddrcm_mem_model_inst.emr_q, 13'h0002);
    chk(ddrcm_mem_model_inst.n_lrst, 2);
    issue(ddrcm_pkg::CMD_LMR, 2'h0, 13'h0080, 8'h00, 1'b1);
    issue(ddrcm_pkg::CMD_LMR, 2'h0, 13'h1000, 8'h00, 1'b1);
    issue(ddrcm_pkg::CMD_LMR, 2'h2, 13'h0002, 8'h00, 1'b1);
    chk(ddrcm_mem_model_inst.emr_q, 13'h0002);
    $display("test mode registers done");
  endtask

  task automatic t_read();
    int k;
    k = 0;
    issue(ddrcm_pkg::CMD_ACT, 2'h1, 13'h0abc, 8'h00, 1'b0);
    issue(ddrcm_pkg::CMD_RD, 2'h1, 13'h0004, 8'h00, 1'b1);
    issue(ddrcm_pkg::CMD_ACT, 2'h1, 13'h0abc, 8'h00, 1'b1);
    settle();
    chk(ddrcm_mem_model_inst.open_q, 4'h2);
    while (dll_ready_o !== 1'b1) begin
      if (++k > 2000) hang();
      @(negedge mclk_i);
    end
    issue(ddrcm_pkg::CMD_RD, 2'h1, 13'h0004, 8'h00, 1'b0);
    issue(ddrcm_pkg::CMD_BST, 2'h0, 13'h0000, 8'h00, 1'b0);
    issue(ddrcm_pkg::CMD_RD, 2'h1, 13'h0404, 8'h00, 1'b0);
    issue(ddrcm_pkg::CMD_BST, 2'h0, 13'h0000, 8'h00, 1'b1);
    settle();
    chk(ddrcm_mem_model_inst.open_q, 4'h0);
    $display("test reads done");
  endtask

  task automatic t_write();
    int k;
    issue(ddrcm_pkg::CMD_ACT, 2'h2, 13'h0010, 8'h00, 1'b0);
    k = ddrcm_mem_model_inst.n_mask;
    issue(ddrcm_pkg::CMD_WR, 2'h2, 13'h0010, 8'h5a, 1'b0);
    repeat (40) @(negedge mclk_i);
    chk(ddrcm_mem_model_inst.n_mask - k, 4);
    issue(ddrcm_pkg::CMD_PRE, 2'h2, 13'h0000, 8'h00, 1'b0);
    issue(ddrcm_pkg::CMD_ACT, 2'h0, 13'h0001, 8'h00, 1'b0);
    issue(ddrcm_pkg::CMD_ACT, 2'h3, 13'h1fff, 8'h00, 1'b0);
    settle();
    chk(ddrcm_mem_model_inst.open_q, 4'h9);
    issue(ddrcm_pkg::CMD_PRE, 2'h1, 13'h0400, 8'h00, 1'b0);
    settle();
    chk(ddrcm_mem_model_inst.open_q, 4'h0);
    $display("test writes and precharge done");
  endtask

  task automatic t_refresh();
    issue(ddrcm_pkg::CMD_REF, 2'h0, 13'h0000, 8'h00, 1'b0);
    issue(ddrcm_pkg::CMD_NOP, 2'h0, 13'h0000, 8'h00, 1'b0);
    issue(ddrcm_pkg::CMD_DESEL, 2'h0, 13'h0000, 8'h00, 1'b0);
    settle();
    chk(ddrcm_mem_model_inst.n_ref, 1);
    chk(ddrcm_mem_model_inst.open_q, 4'h0);
    issue(ddrcm_pkg::CMD_SREF, 2'h0, 13'h0000, 8'h00, 1'b0);
    settle();
    chk({mem_cke_o, ddrcm_mem_model_inst.sref_q}, 2'b01);
    issue(ddrcm_pkg::CMD_NOP, 2'h0, 13'h0000, 8'h00, 1'b1);
    issue(ddrcm_pkg::CMD_SREX, 2'h0, 13'h0000, 8'h00, 1'b0);
    chk(dll_ready_o, 1'b0);
    settle();
    chk({mem_cke_o, ddrcm_mem_model_inst.sref_q, ddrcm_mem_model_inst.dll_on_q}, 3'b101);
    issue(ddrcm_pkg::CMD_ACT, 2'h1, 13'h0002, 8'h00, 1'b0);
    issue(ddrcm_pkg::CMD_RD, 2'h1, 13'h0000, 8'h00, 1'b1);
    $display("test refresh done");
  endtask

  initial begin
    repeat (12) @(posedge mclk_i);
    chk({mem_cs_n_o, mem_cke_o, dll_ready_o}, 3'b110);
    chk({mem_ck_o, mem_ck_n_o}, 2'b01);
    rstn_i <= 1'b1;
    t_mode();
    t_read();
    t_write();
    t_refresh();
    summarize();
  end
endmodule
